/* src/hps_consts.svh */
// Operation
// [RULE_01] Serial mode: shared pin samples presence bit one
// [RULE_02] Direct mode: open-drain fault, only while power valid
// [RULE_03] Clock switch enable resets off, latch-updated
// [RULE_04] Bus switch enable resets off, latch-updated
// [RULE_05] Direct mode: clock pin shows capability bit two
// [RULE_06] Direct mode: bus pin shows capability bit one
// [RULE_07] Mode chosen at power valid rising edge
// [RULE_08] System raises power valid after supplies good
// [RULE_09] Output undervoltage checks wait for both gates
// [RULE_10] Dropping power request clears latched fault
// [RULE_11] Direct mode: reset pin shows capability bit three
// [RULE_12] Switch enables change only at latch event; in direct mode the code reloads them from the capability bits every cycle
`ifndef HPS_CONSTS_SVH
`define HPS_CONSTS_SVH
`define HPS_CAP_BIT_ONE 1
`define HPS_CAP_BIT_TWO 2
`define HPS_CAP_BIT_THREE 3
`define HPS_SHIFT_CLK_BIT 0
`define HPS_SHIFT_BUS_BIT 1
`define HPS_SHIFT_RST_BIT 2
`define HPS_MODE_SERIAL 1'h0
`define HPS_MODE_DIRECT 1'h1
`endif

/* src/hps_pkg.sv */
package hps_pkg;
    typedef enum logic [0:0] {
        HPS_SERIAL = 1'b0,
        HPS_DIRECT = 1'b1
    } hps_mode_t;
endpackage : hps_pkg

/* src/hps_edge.sv */
`timescale 1ns/100ps
// Rise/fall detector: registered previous value, combinational outputs
module hps_edge (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sig_i,
    output logic rise_o,
    output logic fall_o
);
    logic prev_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sig_i;
        end
    end

    assign rise_o = sig_i & ~prev_reg;
    assign fall_o = ~sig_i & prev_reg;
endmodule : hps_edge

/* src/hps_slot_mux.sv */
`timescale 1ns/100ps
`include "hps_consts.svh"
module hps_slot_mux #(
    parameter int CAP_W = 4,
    parameter int SHIFT_W = 3
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic SYSTEM_POWER_VALID_I,
    input wire logic MODE_SELECT_I,
    input wire logic SHARED_PIN_I,
    output logic SHARED_PIN_O,
    output logic SHARED_PIN_OE_O,
    output logic SLOT_A_PRESENCE_BIT_ONE_O,
    input wire logic SHIFT_OUT_COMMAND_I,
    input wire logic [SHIFT_W-1:0] SHIFT_DATA_I,
    input wire logic LATCH_CONTROL_I,
    input wire logic [CAP_W-1:0] SLOT_A_CARD_CAPABILITY_I,
    input wire logic SLOT_A_AUX_FAULT_I,
    input wire logic SLOT_A_MAIN_FAULT_I,
    input wire logic SLOT_A_MAIN_POWER_REQUEST_I,
    input wire logic SLOT_A_12V_GATE_DRIVE_I,
    input wire logic SLOT_A_5V3V_GATE_DRIVE_I,
    output logic SLOT_A_CLOCK_SWITCH_EN_O,
    output logic SLOT_A_BUS_SWITCH_EN_O,
    output logic SLOT_A_RESET_PIN_O,
    output logic SLOT_A_MAIN_POWER_ON_O,
    output logic SLOT_A_OUTPUT_UV_ENABLE_O,
    output logic DIRECT_MODE_O
);
    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    logic pg_rise;
    logic req_rise;
    logic req_fall;
    hps_pkg::hps_mode_t mode_reg;

    hps_edge u_pg_edge (
        .clk_i(REF_CLK_I),
        .rst_n_i(rst_n),
        .sig_i(SYSTEM_POWER_VALID_I),
        .rise_o(pg_rise),
        .fall_o()
    );

    hps_edge u_req_edge (
        .clk_i(REF_CLK_I),
        .rst_n_i(rst_n),
        .sig_i(SLOT_A_MAIN_POWER_REQUEST_I),
        .rise_o(req_rise),
        .fall_o(req_fall)
    );

    // Strap captured only at the edge, so later toggles are harmless
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= hps_pkg::HPS_SERIAL;
        end else if (pg_rise) begin
            mode_reg <= hps_pkg::hps_mode_t'(MODE_SELECT_I); // RULE_07
        end
    end

    logic direct;
    assign direct = (mode_reg == hps_pkg::HPS_DIRECT);
    assign DIRECT_MODE_O = direct;

    // ----------------------------------------
    // Serial shift latch
    // ----------------------------------------
    logic [SHIFT_W-1:0] shift_reg;
    logic [SHIFT_W-1:0] latched_reg;
    logic shift_valid_reg;

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
            shift_valid_reg <= 1'b0;
        end else if (SHIFT_OUT_COMMAND_I) begin
            shift_reg <= SHIFT_DATA_I;
            shift_valid_reg <= 1'b1;
        end else if (LATCH_CONTROL_I) begin
            shift_valid_reg <= 1'b0;
        end
    end

    // In serial mode pins move only on the latch, never mid-shift
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            latched_reg <= '0; // RULE_03 RULE_04
        end else if (LATCH_CONTROL_I && shift_valid_reg) begin
            latched_reg <= shift_reg; // RULE_12
        end
    end

    // ----------------------------------------
    // Fault latch and power
    // ----------------------------------------
    logic fault_reg;
    logic power_reg;

    // Set wins over the clear from a dropping request
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            fault_reg <= 1'b0;
        end else if (SLOT_A_AUX_FAULT_I || SLOT_A_MAIN_FAULT_I) begin
            fault_reg <= 1'b1;
        end else if (req_fall) begin
            fault_reg <= 1'b0; // RULE_10
        end
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            power_reg <= 1'b0;
        end else begin
            power_reg <= direct && SLOT_A_MAIN_POWER_REQUEST_I && !fault_reg; // RULE_10
        end
    end
    assign SLOT_A_MAIN_POWER_ON_O = power_reg;

    // ----------------------------------------
    // Pin muxing
    // ----------------------------------------
    logic clk_pin_reg;
    logic bus_pin_reg;
    logic rst_pin_reg;
    logic pres_reg;
    logic fault_drive_reg;
    logic uv_en_reg;

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            clk_pin_reg <= 1'b0;
            bus_pin_reg <= 1'b0;
            rst_pin_reg <= 1'b0;
        end else if (direct) begin
            clk_pin_reg <= SLOT_A_CARD_CAPABILITY_I[`HPS_CAP_BIT_TWO]; // RULE_05
            bus_pin_reg <= SLOT_A_CARD_CAPABILITY_I[`HPS_CAP_BIT_ONE]; // RULE_06
            rst_pin_reg <= SLOT_A_CARD_CAPABILITY_I[`HPS_CAP_BIT_THREE]; // RULE_11
        end else begin
            clk_pin_reg <= latched_reg[`HPS_SHIFT_CLK_BIT]; // RULE_03
            bus_pin_reg <= latched_reg[`HPS_SHIFT_BUS_BIT]; // RULE_04
            rst_pin_reg <= latched_reg[`HPS_SHIFT_RST_BIT];
        end
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pres_reg <= 1'b0;
        end else if (!direct) begin
            pres_reg <= SHARED_PIN_I; // RULE_01
        end
    end

    // Fault hidden while power valid is low; the system must not raise it early
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            fault_drive_reg <= 1'b0;
        end else begin
            fault_drive_reg <= direct && SYSTEM_POWER_VALID_I && fault_reg; // RULE_02 RULE_08
        end
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            uv_en_reg <= 1'b0;
        end else begin
            uv_en_reg <= SLOT_A_12V_GATE_DRIVE_I && SLOT_A_5V3V_GATE_DRIVE_I; // RULE_09
        end
    end

    assign SLOT_A_CLOCK_SWITCH_EN_O = clk_pin_reg;
    assign SLOT_A_BUS_SWITCH_EN_O = bus_pin_reg;
    assign SLOT_A_RESET_PIN_O = rst_pin_reg;
    assign SLOT_A_PRESENCE_BIT_ONE_O = pres_reg;
    assign SHARED_PIN_O = 1'b0;
    assign SHARED_PIN_OE_O = fault_drive_reg; // RULE_02
    assign SLOT_A_OUTPUT_UV_ENABLE_O = uv_en_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_mode_hold;
        @(posedge REF_CLK_I) disable iff (!rst_n) !pg_rise |=> $stable(mode_reg);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("Mode changed without power valid edge"); // RULE_07

    property p_mode_take;
        @(posedge REF_CLK_I) disable iff (!rst_n) pg_rise |=> mode_reg == $past(MODE_SELECT_I);
    endproperty
    a_mode_take: assert property (p_mode_take) else $error("Mode not captured at edge"); // RULE_07

    property p_latch_only;
        @(posedge REF_CLK_I) disable iff (!rst_n) !(LATCH_CONTROL_I && shift_valid_reg) |=> $stable(latched_reg);
    endproperty
    a_latch_only: assert property (p_latch_only) else $error("Latch moved without latch event"); // RULE_12

    property p_clk_serial;
        @(posedge REF_CLK_I) disable iff (!rst_n)
            !direct ##1 !direct |-> SLOT_A_CLOCK_SWITCH_EN_O == $past(latched_reg[`HPS_SHIFT_CLK_BIT]);
    endproperty
    a_clk_serial: assert property (p_clk_serial) else $error("Clock switch enable not from latch"); // RULE_03

    property p_bus_serial;
        @(posedge REF_CLK_I) disable iff (!rst_n)
            !direct ##1 !direct |-> SLOT_A_BUS_SWITCH_EN_O == $past(latched_reg[`HPS_SHIFT_BUS_BIT]);
    endproperty
    a_bus_serial: assert property (p_bus_serial) else $error("Bus switch enable not from latch"); // RULE_04

    property p_cap_two;
        @(posedge REF_CLK_I) disable iff (!rst_n)
            direct ##1 direct |-> SLOT_A_CLOCK_SWITCH_EN_O == $past(SLOT_A_CARD_CAPABILITY_I[`HPS_CAP_BIT_TWO]);
    endproperty
    a_cap_two: assert property (p_cap_two) else $error("Capability bit two wrong"); // RULE_05

    property p_cap_one;
        @(posedge REF_CLK_I) disable iff (!rst_n)
            direct ##1 direct |-> SLOT_A_BUS_SWITCH_EN_O == $past(SLOT_A_CARD_CAPABILITY_I[`HPS_CAP_BIT_ONE]);
    endproperty
    a_cap_one: assert property (p_cap_one) else $error("Capability bit one wrong"); // RULE_06

    property p_cap_three;
        @(posedge REF_CLK_I) disable iff (!rst_n)
            direct ##1 direct |-> SLOT_A_RESET_PIN_O == $past(SLOT_A_CARD_CAPABILITY_I[`HPS_CAP_BIT_THREE]);
    endproperty
    a_cap_three: assert property (p_cap_three) else $error("Capability bit three wrong"); // RULE_11

    property p_fault_gate;
        @(posedge REF_CLK_I) disable iff (!rst_n) SHARED_PIN_OE_O |-> $past(SYSTEM_POWER_VALID_I) && $past(direct);
    endproperty
    a_fault_gate: assert property (p_fault_gate) else $error("Fault driven outside direct power valid"); // RULE_02

    property p_uv_gate;
        @(posedge REF_CLK_I) disable iff (!rst_n)
            SLOT_A_OUTPUT_UV_ENABLE_O |-> $past(SLOT_A_12V_GATE_DRIVE_I) && $past(SLOT_A_5V3V_GATE_DRIVE_I);
    endproperty
    a_uv_gate: assert property (p_uv_gate) else $error("Undervoltage check enabled early"); // RULE_09

    property p_fault_clear;
        @(posedge REF_CLK_I) disable iff (!rst_n)
            req_fall && !SLOT_A_AUX_FAULT_I && !SLOT_A_MAIN_FAULT_I |=> !fault_reg;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("Fault not cleared by request drop"); // RULE_10

    property p_pres;
        @(posedge REF_CLK_I) disable iff (!rst_n) !direct && $past(rst_n) |=> pres_reg == $past(SHARED_PIN_I);
    endproperty
    a_pres: assert property (p_pres) else $error("Presence bit not sampled"); // RULE_01
endmodule : hps_slot_mux

/* test/hps_slot_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Slot card on the shared pin
// ----------------------------------------
module hps_slot_model (
    input wire logic drive_i,
    input wire logic drive_oe_i,
    input wire logic presence_i,
    output logic level_o
);
    // Open drain: the device only pulls low, else the card decides
    assign level_o = drive_oe_i ? drive_i : presence_i;
endmodule : hps_slot_model

/* test/hot_plug_slot_signal_mux_tb.sv */
`timescale 1ns/100ps
module hot_plug_slot_signal_mux_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic pg = 1'b0;
    logic mode = 1'b0;
    logic card_prs = 1'b1;
    logic sh_cmd = 1'b0;
    logic [2:0] sh_data = 3'h0;
    logic latch = 1'b0;
    logic [3:0] cap = 4'h0;
    logic aux_f = 1'b0;
    logic main_f = 1'b0;
    logic req = 1'b0;
    logic g12 = 1'b0;
    logic g5 = 1'b0;
    logic pin_o, pin_oe, pin_lvl, prs, clk_en, bus_en, rst_pin, pwr_on, uv_en, direct;
    int fails = 0;
    int compares = 0;
    logic [31:0] seed = 32'h45;
    logic [2:0] lat = 3'h0;

    always #50 clk = ~clk;

    hps_slot_mux DUT (.REF_CLK_I(clk), .NRST_I(nrst), .SYSTEM_POWER_VALID_I(pg), .MODE_SELECT_I(mode),
        .SHARED_PIN_I(pin_lvl), .SHARED_PIN_O(pin_o), .SHARED_PIN_OE_O(pin_oe), .SLOT_A_PRESENCE_BIT_ONE_O(prs),
        .SHIFT_OUT_COMMAND_I(sh_cmd), .SHIFT_DATA_I(sh_data), .LATCH_CONTROL_I(latch),
        .SLOT_A_CARD_CAPABILITY_I(cap), .SLOT_A_AUX_FAULT_I(aux_f), .SLOT_A_MAIN_FAULT_I(main_f),
        .SLOT_A_MAIN_POWER_REQUEST_I(req), .SLOT_A_12V_GATE_DRIVE_I(g12), .SLOT_A_5V3V_GATE_DRIVE_I(g5),
        .SLOT_A_CLOCK_SWITCH_EN_O(clk_en), .SLOT_A_BUS_SWITCH_EN_O(bus_en), .SLOT_A_RESET_PIN_O(rst_pin),
        .SLOT_A_MAIN_POWER_ON_O(pwr_on), .SLOT_A_OUTPUT_UV_ENABLE_O(uv_en), .DIRECT_MODE_O(direct));

    hps_slot_model u_card (.drive_i(pin_o), .drive_oe_i(pin_oe), .presence_i(card_prs), .level_o(pin_lvl));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    // Pin order {reset, bus, clock}
    function automatic logic [2:0] exp_pins(input logic dm, input logic [2:0] l, input logic [3:0] c);
        return dm ? {c[3], c[1], c[2]} : l;
    endfunction : exp_pins

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic chk(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : chk

    task automatic chk_pins(input logic [2:0] e);
        chk("clock_switch_en", e[0], clk_en);
        chk("bus_switch_en", e[1], bus_en);
        chk("reset_pin", e[2], rst_pin);
    endtask : chk_pins

    // Shift in one cycle, optional latch in the next; with do_latch low the old latched value stays visible
    task automatic shift_latch(input logic [2:0] d, input logic do_latch);
        sh_cmd = 1'b1;
        sh_data = d;
        cyc(1);
        sh_cmd = 1'b0;
        latch = do_latch;
        cyc(1);
        latch = 1'b0;
        cyc(3);
    endtask : shift_latch

    task automatic fault_pulse(input logic main);
        aux_f = !main;
        main_f = main;
        cyc(1);
        aux_f = 1'b0;
        main_f = 1'b0;
        cyc(3);
    endtask : fault_pulse

    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        cyc(12);
        nrst = 1'b1;
        cyc(4);
        chk_pins(3'h0);
        pg = 1'b1;
        cyc(3);
        chk("direct_mode", 1'b0, direct);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            card_prs = seed[0];
            cyc(3);
            chk("presence", seed[0], prs);
        end
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            shift_latch(seed[2:0], seed[3]);
            if (seed[3]) begin
                lat = seed[2:0];
            end
            chk_pins(exp_pins(1'b0, lat, cap));
        end
        shift_latch(3'h5, 1'b1);
        lat = 3'h5;
        latch = 1'b1;
        cyc(1);
        latch = 1'b0;
        cyc(3);
        chk_pins(3'h5);
        fault_pulse(1'b0);
        chk("fault_oe", 1'b0, pin_oe);
        req = 1'b1;
        cyc(2);
        req = 1'b0;
        cyc(2);
        pg = 1'b0;
        mode = 1'b1;
        cyc(2);
        pg = 1'b1;
        cyc(3);
        chk("direct_mode", 1'b1, direct);
        mode = 1'b0;
        cyc(3);
        chk("direct_mode", 1'b1, direct);
        chk("fault_oe", 1'b0, pin_oe);
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            cap = seed[3:0];
            g12 = seed[4];
            g5 = seed[5];
            req = seed[6];
            cyc(3);
            chk_pins(exp_pins(1'b1, lat, cap));
            chk("uv_enable", g12 & g5, uv_en);
            chk("main_power_on", req, pwr_on);
        end
        req = 1'b1;
        card_prs = 1'b1;
        cyc(3);
        fault_pulse(1'b1);
        chk("fault_oe", 1'b1, pin_oe);
        chk("shared_level", 1'b0, pin_lvl);
        chk("main_power_on", 1'b0, pwr_on);
        pg = 1'b0;
        mode = 1'b1;
        cyc(3);
        chk("fault_oe", 1'b0, pin_oe);
        pg = 1'b1;
        cyc(3);
        chk("fault_oe", 1'b1, pin_oe);
        req = 1'b0;
        cyc(3);
        chk("fault_oe", 1'b0, pin_oe);
        req = 1'b1;
        fault_pulse(1'b0);
        chk("fault_oe", 1'b1, pin_oe);
        nrst = 1'b0;
        cyc(2);
        chk("direct_mode", 1'b0, direct);
        chk_pins(3'h0);
        report_and_stop();
    end

    // Whole run is about 176 cycles, well under the 2000-cycle limit
    initial begin
        #(100 * 2000);
        fails++;
        report_and_stop();
    end
endmodule : hot_plug_slot_signal_mux_tb
